//--- hw/mcf_pkg.sv
package mcf_pkg;

  // Bus and word widths
  localparam int DW = 32;
  localparam int AW = 8;

  // Register byte offsets
  localparam logic [AW-1:0] OFF_CMD     = 8'h00;
  localparam logic [AW-1:0] OFF_SWITCH  = 8'h04;
  localparam logic [AW-1:0] OFF_DISPLAY = 8'h08;
  localparam logic [AW-1:0] OFF_CTRL    = 8'h0c;
  localparam logic [AW-1:0] OFF_STATUS  = 8'h10;
  localparam logic [AW-1:0] OFF_PRIO    = 8'h14;
  localparam logic [AW-1:0] OFF_SLOT    = 8'h18;

  // Reset values
  localparam logic [DW-1:0] RST_WORD = 32'h0000_0000;
  localparam logic [4:0]    RST_CTRL = 5'h00;
  localparam logic [15:0]   RST_PRIO = 16'h0000;

  // Command word fields
  localparam int CMD_CODE_LSB  = 0;
  localparam int CMD_FMT_LSB   = 4;
  localparam int CMD_SEL_LSB   = 8;
  localparam int CMD_VP_LSB    = 16;
  localparam int CMD_TGT_LSB   = 20;
  localparam int CMD_BURST_LSB = 24;

  // Command codes
  localparam logic [3:0] CMD_SW_DISP   = 4'h1;
  localparam logic [3:0] CMD_RD_TGT    = 4'h2;
  localparam logic [3:0] CMD_RD_MEM    = 4'h3;
  localparam logic [3:0] CMD_RD_ROM    = 4'h4;
  localparam logic [3:0] CMD_WR_SW     = 4'h5;
  localparam logic [3:0] CMD_WR_DISP   = 4'h6;
  localparam logic [3:0] CMD_WR_MEM    = 4'h7;
  localparam logic [3:0] CMD_LOCK      = 4'h8;
  localparam logic [3:0] CMD_UNLOCK    = 4'h9;
  localparam logic [3:0] CMD_REG_RESET = 4'ha;
  localparam logic [3:0] CMD_REG_SET   = 4'hb;
  localparam logic [3:0] CMD_BURST     = 4'hc;

  // Transfer targets
  localparam logic [3:0] TGT_ADDR = 4'h0;
  localparam logic [3:0] TGT_DATA = 4'h1;
  localparam logic [3:0] TGT_NI   = 4'h2;
  localparam logic [3:0] TGT_PC   = 4'h3;
  localparam logic [3:0] TGT_RF   = 4'h4;
  localparam logic [3:0] TGT_CR   = 4'h5;
  localparam logic [3:0] TGT_IR   = 4'h6;
  localparam logic [3:0] TGT_MI   = 4'h7;
  localparam logic [3:0] TGT_BC   = 4'h8;

  // Control register bits
  localparam int CTRL_W        = 5;
  localparam int CTL_HALT_EVEN = 0;
  localparam int CTL_HALT_ODD  = 1;
  localparam int CTL_ASYNC     = 2;
  localparam int CTL_STOP      = 3;
  localparam int CTL_BC_LOCK   = 4;

  // Time slot entry bits
  localparam int ENT_W      = 8;
  localparam int ENT_ACTIVE = 3;
  localparam int ENT_AVAIL  = 4;
  localparam int ENT_TEST   = 5;

  // Transfer enable vector positions
  localparam int EN_W       = 24;
  localparam int EN_ADDR_IN = 0;
  localparam int EN_DATA_IN = 1;
  localparam int EN_NI_IN   = 2;
  localparam int EN_PC_IN   = 3;
  localparam int EN_ADDR_OUT= 4;
  localparam int EN_DATA_OUT= 5;
  localparam int EN_NI_OUT  = 6;
  localparam int EN_PC_OUT  = 7;
  localparam int EN_ROM_NI  = 8;
  localparam int EN_RF_IN   = 9;
  localparam int EN_RF_OUT  = 10;
  localparam int EN_CR_IN   = 11;
  localparam int EN_CR_OUT  = 12;
  localparam int EN_IR_OUT  = 13;
  localparam int EN_IR_IN   = 14;
  localparam int EN_MI_IN   = 15;
  localparam int EN_MI_OUT  = 16;
  localparam int EN_BC_OUT  = 17;
  localparam int EN_BC_IN   = 18;
  localparam int EN_RD_REQ  = 19;
  localparam int EN_WR_REQ  = 20;
  localparam int EN_VP_RES  = 21;
  localparam int EN_VP_SET  = 22;
  localparam int EN_BURST   = 23;

  // Controller states
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_EXEC = 4'b0010,
    ST_WAIT = 4'b0100,
    ST_ILL  = 4'b1000
  } mcf_state_t;

endpackage

//--- hw/mcf_slot_mem.sv
`timescale 1ns/1ps
`default_nettype none
module mcf_slot_mem #(
  parameter int W = 8,
  parameter int D = 16
) (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic                 we,
  input  wire logic [$clog2(D)-1:0] waddr,
  input  wire logic [W-1:0]         wdata,
  input  wire logic [$clog2(D)-1:0] raddr,
  output logic      [W-1:0]         rdata
);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [W-1:0]        rd;
  } mcf_mem_t;

  mcf_mem_t mem_reg;
  mcf_mem_t mem_next;

  // Write port and registered read port
  always_comb begin
    mem_next = mem_reg;
    mem_next.rd = mem_reg.mem[raddr];
    if (we) begin
      mem_next.mem[waddr] = wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      mem_reg <= '0;
    end else begin
      mem_reg <= mem_next;
    end
  end

  assign rdata = mem_reg.rd;

endmodule
`default_nettype wire

//--- hw/mcf_top.sv
// What this block does
// - Test mode enables maintenance logic and raises every normal-gate disable.
// - Test-mode control gate enables are held at one continuously.
// - Master clear resets normal and test-mode control flip-flops alike.
// - Source select true puts switch register on second bus, else display.
// - Display-load select true loads switch data, else maintenance bus data.
// - Code A issues register reset control, code B issues register set control.
// - One lock control locks program counters while true, unlocks while false.
// - Halt on even or odd state; separate async buffer-control enable.
// - Load control copies the burst field to the clock burst counter.
// - Stop control halts the time slot counter.
// - Helper gives look-ahead code, active, buffer availability and under-test.
// - Compare indication while switch and display registers are equal.
// - Report current slot number, processor code and active flag.
// - File byte and halfword write enables come from the format field.
// - Busy, counter-locked and illegal-command status bits track each command.
// - Test mode: processor code with read enable picks one of four reads.
// - Register-file byte write enables are write enable ANDed with byte enables.
// - Microinstruction load enable with two select bits gives three loads.
// - Slot entry goes to helper; priority and protect follow current code.
// - Forward test mode to buffer card and raise its read/write requests.
// - Transfer enables move bus data into registers or registers onto bus.
// - Instruction-register read and load enables pass on inverted.
// - Code 1 copies switch to display; codes 2 to 4 load bus data.
//
// The implementer's own choices: strobed register access and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module mcf_top
  import mcf_pkg::*;
#(
  parameter int SLOTS = 16
) (
  input  wire logic                   CLK,
  input  wire logic                   RST,
  input  wire logic [mcf_pkg::AW-1:0] ADDR,
  input  wire logic [mcf_pkg::DW-1:0] WDATA,
  input  wire logic                   WR,
  input  wire logic                   RD,
  output logic      [mcf_pkg::DW-1:0] RDATA,
  input  wire logic                   TEST_MODE_PIN,
  input  wire logic [mcf_pkg::DW-1:0] MAINT_DATA_BUS,
  input  wire logic                   MEM_READY,
  output logic                        TEST_MODE_INDICATOR,
  output logic                        AU_NORMAL_GATE_DISABLE,
  output logic                        CRFILE_NORMAL_GATE_DISABLE,
  output logic                        PC_NORMAL_GATE_DISABLE,
  output logic                        CRFILE_TEST_GATE_ENABLE,
  output logic                        PC_TEST_GATE_ENABLE,
  output logic                        SYNC_BUFFER_TEST_ENABLE,
  output logic      [mcf_pkg::DW-1:0] SECOND_AU_BUS,
  output logic                        BUS_SOURCE_SELECT,
  output logic                        DISPLAY_LOAD_SELECT,
  output logic      [mcf_pkg::DW-1:0] DISPLAY_REGISTER,
  output logic    [mcf_pkg::EN_W-1:0] XFER_EN,
  output logic                        MERGE_IR_READ_N,
  output logic                        MERGE_IR_LOAD_N,
  output logic                        COUNTER_LOCK_CTRL,
  output logic                        HALT_ON_EVEN_STATE,
  output logic                        HALT_ON_ODD_STATE,
  output logic                        ASYNC_BUFFER_CTRL_ENABLE,
  output logic                        BUFFER_CTRL_TEST_LOCK,
  output logic                        SLOT_COUNTER_STOP,
  output logic      [7:0]             BURST_VALUE,
  output logic      [3:0]             CRFILE_BYTE_WE,
  output logic      [1:0]             CRFILE_HALF_WE,
  output logic      [3:0]             REGFILE_BYTE_WE,
  output logic      [1:0]             REGFILE_HALF_WE,
  output logic      [3:0]             REGFILE_READ_SEL,
  output logic      [2:0]             WORD_SEL,
  output logic      [2:0]             MICROINSTR_LOAD_SEL,
  output logic      [2:0]             LA3_VP_CODE,
  output logic                        LA3_ACTIVE,
  output logic                        LA2_BUF_AVAIL,
  output logic                        LA2_UNDER_TEST,
  output logic [$clog2(SLOTS)-1:0]    CUR_SLOT,
  output logic      [2:0]             CUR_VP_CODE,
  output logic                        CUR_VP_ACTIVE,
  output logic                        COMPARE,
  output logic                        BUF_PRIORITY,
  output logic                        BUF_PROTECT
);

  localparam int SW = $clog2(SLOTS);

  // Slot table must be a power of two of at least eight entries
  if (SLOTS < 8 || (SLOTS & (SLOTS - 1)) != 0) begin : g_bad_slots
    $error("SLOTS must be a power of two, at least 8");
  end

  typedef struct packed {
    mcf_state_t      st;
    logic [DW-1:0]   cmd;
    logic [DW-1:0]   sw;
    logic [DW-1:0]   disp;
    logic [CTRL_W-1:0] ctrl;
    logic [15:0]     pp;
    logic [2:0]      sy;
    logic            tm;
    logic            locked;
    logic [SW-1:0]   slot;
    logic [ENT_W-1:0] e2;
    logic [ENT_W-1:0] e1;
    logic [ENT_W-1:0] e0;
    logic [EN_W-1:0] en;
    logic [DW-1:0]   au;
    logic [DW-1:0]   rdata;
    logic            srcsel;
    logic            dlsel;
    logic            cmp;
    logic            pri;
    logic            pro;
    logic [3:0]      crbe;
    logic [1:0]      crhw;
    logic [3:0]      rfbe;
    logic [1:0]      rfhw;
    logic [3:0]      rsel;
    logic [2:0]      wsel;
    logic [2:0]      misel;
  } mcf_regs_t;

  mcf_regs_t        r_reg;
  mcf_regs_t        r_next;
  logic [ENT_W-1:0] la_entry;
  logic             slot_we;

  // Command legality, checked when software writes the command
  function automatic logic cmd_legal(input logic [DW-1:0] w);
    logic [3:0] c;
    logic [3:0] t;
    c = w[CMD_CODE_LSB +: 4];
    t = w[CMD_TGT_LSB +: 4];
    cmd_legal = (c >= CMD_SW_DISP) && (c <= CMD_BURST);
    if (c == CMD_RD_TGT || c == CMD_WR_SW || c == CMD_WR_DISP) begin
      cmd_legal = cmd_legal && (t <= TGT_BC);
    end
  endfunction

  // One transfer enable for a target, inward or outward
  function automatic logic [EN_W-1:0] tgt_en(input logic [3:0] t, input logic wr);
    logic [EN_W-1:0] e;
    e = '0;
    case (t)
      TGT_ADDR: e[wr ? EN_ADDR_IN : EN_ADDR_OUT] = 1'b1;
      TGT_DATA: e[wr ? EN_DATA_IN : EN_DATA_OUT] = 1'b1;
      TGT_NI:   e[wr ? EN_NI_IN : EN_NI_OUT] = 1'b1;
      TGT_PC:   e[wr ? EN_PC_IN : EN_PC_OUT] = 1'b1;
      TGT_RF:   e[wr ? EN_RF_IN : EN_RF_OUT] = 1'b1;
      TGT_CR:   e[wr ? EN_CR_IN : EN_CR_OUT] = 1'b1;
      TGT_IR:   e[wr ? EN_IR_IN : EN_IR_OUT] = 1'b1;
      TGT_MI:   e[wr ? EN_MI_IN : EN_MI_OUT] = 1'b1;
      TGT_BC:   e[wr ? EN_BC_IN : EN_BC_OUT] = 1'b1;
      default:  e = '0;
    endcase
    return e;
  endfunction

  // Time slot table, read four ahead so its register holds slot plus three
  assign slot_we = WR && (ADDR == OFF_SLOT);

  mcf_slot_mem #(
    .W (ENT_W),
    .D (SLOTS)
  ) u_slot_mem (
    .clk   (CLK),
    .rst   (RST),
    .we    (slot_we),
    .waddr (WDATA[8 +: SW]),
    .wdata (WDATA[ENT_W-1:0]),
    .raddr (r_reg.slot + SW'(4)),
    .rdata (la_entry)
  );

  // Next state of everything
  always_comb begin
    logic [3:0]      code;
    logic [3:0]      tgt;
    logic [3:0]      fmt;
    logic [5:0]      sel;
    logic [1:0]      vp;
    logic [EN_W-1:0] en;
    logic            wr_cmd;
    logic            done;
    code = r_reg.cmd[CMD_CODE_LSB +: 4];
    tgt = r_reg.cmd[CMD_TGT_LSB +: 4];
    fmt = r_reg.cmd[CMD_FMT_LSB +: 4];
    sel = r_reg.cmd[CMD_SEL_LSB +: 6];
    vp = r_reg.cmd[CMD_VP_LSB +: 2];
    en = '0;
    done = 1'b0;
    wr_cmd = WR && (ADDR == OFF_CMD) && (r_reg.st == ST_IDLE || r_reg.st == ST_ILL);
    r_next = r_reg;
    r_next.dlsel = 1'b0;

    // Test mode pin: three stages, change taken when second and third agree
    r_next.sy = {r_reg.sy[1:0], TEST_MODE_PIN};
    if (r_reg.sy[1] == r_reg.sy[2]) begin
      r_next.tm = r_reg.sy[2];
    end

    // Slot counter and look-ahead pipeline
    if (!r_reg.ctrl[CTL_STOP]) begin
      r_next.slot = r_reg.slot + SW'(1);
      r_next.e2 = la_entry;
      r_next.e1 = r_reg.e2;
      r_next.e0 = r_reg.e1;
    end

    // Register writes
    if (WR) begin
      case (ADDR)
        OFF_SWITCH:  r_next.sw = WDATA;
        OFF_DISPLAY: r_next.disp = WDATA;
        OFF_CTRL:    r_next.ctrl = WDATA[CTRL_W-1:0];
        OFF_PRIO:    r_next.pp = WDATA[15:0];
        default:     r_next.pp = r_reg.pp;
      endcase
    end

    // Register reads, answered one cycle later
    r_next.rdata = '0;
    if (RD) begin
      case (ADDR)
        OFF_CMD:     r_next.rdata = r_reg.cmd;
        OFF_SWITCH:  r_next.rdata = r_reg.sw;
        OFF_DISPLAY: r_next.rdata = r_reg.disp;
        OFF_CTRL:    r_next.rdata = {{(DW-CTRL_W){1'b0}}, r_reg.ctrl};
        OFF_STATUS:  r_next.rdata = {27'h0, r_reg.cmp, r_reg.tm, r_reg.st == ST_ILL,
                                     r_reg.locked, r_reg.st == ST_EXEC || r_reg.st == ST_WAIT};
        OFF_PRIO:    r_next.rdata = {16'h0, r_reg.pp};
        OFF_SLOT:    r_next.rdata = {16'h0, 4'(r_reg.slot), 4'h0, r_reg.e0};
        default:     r_next.rdata = '0;
      endcase
    end

    // Maintenance command controller
    case (r_reg.st)
      ST_IDLE, ST_ILL: begin
        if (wr_cmd) begin
          r_next.cmd = WDATA;
          r_next.st = cmd_legal(WDATA) ? ST_EXEC : ST_ILL;
        end
      end
      ST_EXEC: begin
        r_next.st = ST_IDLE;
        case (code)
          CMD_SW_DISP: begin
            r_next.disp = r_reg.sw;
            r_next.dlsel = 1'b1;
          end
          CMD_RD_TGT: begin
            en = tgt_en(tgt, 1'b0);
            r_next.st = ST_WAIT;
          end
          CMD_RD_MEM, CMD_WR_MEM: begin
            r_next.au = r_reg.sw;
            r_next.srcsel = 1'b1;
            en[EN_ADDR_IN] = 1'b1;
            en[EN_RD_REQ] = (code == CMD_RD_MEM);
            r_next.st = ST_WAIT;
          end
          CMD_RD_ROM: begin
            r_next.au = r_reg.sw;
            r_next.srcsel = 1'b1;
            en[EN_ROM_NI] = 1'b1;
            r_next.st = ST_WAIT;
          end
          CMD_WR_SW: begin
            r_next.au = r_reg.sw;
            r_next.srcsel = 1'b1;
            en = tgt_en(tgt, 1'b1);
          end
          CMD_WR_DISP: begin
            r_next.au = r_reg.disp;
            r_next.srcsel = 1'b0;
            en = tgt_en(tgt, 1'b1);
          end
          CMD_LOCK:      r_next.locked = 1'b1;
          CMD_UNLOCK:    r_next.locked = 1'b0;
          CMD_REG_RESET: en[EN_VP_RES] = 1'b1;
          CMD_REG_SET:   en[EN_VP_SET] = 1'b1;
          CMD_BURST:     en[EN_BURST] = 1'b1;
          default:       r_next.st = ST_ILL;
        endcase
      end
      ST_WAIT: begin
        case (code)
          CMD_RD_TGT: done = 1'b1;
          CMD_WR_MEM: begin
            r_next.au = r_reg.disp;
            r_next.srcsel = 1'b0;
            en[EN_DATA_IN] = 1'b1;
            en[EN_WR_REQ] = 1'b1;
            done = MEM_READY;
          end
          default: done = MEM_READY;
        endcase
        if (done) begin
          r_next.st = ST_IDLE;
          if (code != CMD_WR_MEM) begin
            r_next.disp = MAINT_DATA_BUS;
          end
        end
      end
      default: r_next.st = ST_IDLE;
    endcase

    // Registered expansions of the transfer enables
    r_next.en = en;
    r_next.crbe = en[EN_CR_IN] ? fmt : 4'h0;
    r_next.crhw = en[EN_CR_IN] ? {&fmt[3:2], &fmt[1:0]} : 2'h0;
    r_next.rfbe = en[EN_RF_IN] ? fmt : 4'h0;
    r_next.rfhw = en[EN_RF_IN] ? {&fmt[3:2], &fmt[1:0]} : 2'h0;
    r_next.rsel = (r_reg.tm && en[EN_RF_OUT]) ? 4'(4'h1 << vp) : 4'h0;
    r_next.wsel = r_reg.tm ? sel[2:0] : 3'h0;
    r_next.misel = (en[EN_MI_IN] && sel[1:0] != 2'h3) ? 3'(3'h1 << sel[1:0]) : 3'h0;
    r_next.cmp = (r_reg.sw == r_reg.disp);
    r_next.pri = r_reg.pp[r_next.e0[2:0]];
    r_next.pro = r_reg.pp[8 + r_next.e0[2:0]];
  end

  // State register; master clear returns every control flip-flop to rest
  always_ff @(posedge CLK) begin
    if (RST) begin
      r_reg <= '{st: ST_IDLE, cmd: RST_WORD, sw: RST_WORD, disp: RST_WORD,
                 ctrl: RST_CTRL, pp: RST_PRIO, au: RST_WORD, rdata: RST_WORD,
                 default: '0};
    end else begin
      r_reg <= r_next;
    end
  end

  // Normal-gate disables and sync buffer test enable follow the test mode indicator; test gate enables are held at one
  assign TEST_MODE_INDICATOR = r_reg.tm;
  assign AU_NORMAL_GATE_DISABLE = r_reg.tm;
  assign CRFILE_NORMAL_GATE_DISABLE = r_reg.tm;
  assign PC_NORMAL_GATE_DISABLE = r_reg.tm;
  assign CRFILE_TEST_GATE_ENABLE = 1'b1;
  assign PC_TEST_GATE_ENABLE = 1'b1;
  assign SYNC_BUFFER_TEST_ENABLE = r_reg.tm;

  // Data paths and transfer controls
  assign RDATA = r_reg.rdata;
  assign SECOND_AU_BUS = r_reg.au;
  assign BUS_SOURCE_SELECT = r_reg.srcsel;
  assign DISPLAY_LOAD_SELECT = r_reg.dlsel;
  assign DISPLAY_REGISTER = r_reg.disp;
  assign XFER_EN = r_reg.en;
  assign MERGE_IR_READ_N = ~r_reg.en[EN_IR_OUT];
  assign MERGE_IR_LOAD_N = ~r_reg.en[EN_IR_IN];
  assign COUNTER_LOCK_CTRL = r_reg.locked;
  assign HALT_ON_EVEN_STATE = r_reg.ctrl[CTL_HALT_EVEN];
  assign HALT_ON_ODD_STATE = r_reg.ctrl[CTL_HALT_ODD];
  assign ASYNC_BUFFER_CTRL_ENABLE = r_reg.ctrl[CTL_ASYNC];
  assign BUFFER_CTRL_TEST_LOCK = r_reg.ctrl[CTL_BC_LOCK];
  assign SLOT_COUNTER_STOP = r_reg.ctrl[CTL_STOP];
  assign BURST_VALUE = r_reg.cmd[CMD_BURST_LSB +: 8];
  assign CRFILE_BYTE_WE = r_reg.crbe;
  assign CRFILE_HALF_WE = r_reg.crhw;
  assign REGFILE_BYTE_WE = r_reg.rfbe;
  assign REGFILE_HALF_WE = r_reg.rfhw;
  assign REGFILE_READ_SEL = r_reg.rsel;
  assign WORD_SEL = r_reg.wsel;
  assign MICROINSTR_LOAD_SEL = r_reg.misel;

  // Slot status and look-ahead
  assign LA3_VP_CODE = la_entry[2:0];
  assign LA3_ACTIVE = la_entry[ENT_ACTIVE];
  assign LA2_BUF_AVAIL = r_reg.e2[ENT_AVAIL];
  assign LA2_UNDER_TEST = r_reg.e2[ENT_TEST];
  assign CUR_SLOT = r_reg.slot;
  assign CUR_VP_CODE = r_reg.e0[2:0];
  assign CUR_VP_ACTIVE = r_reg.e0[ENT_ACTIVE];
  assign COMPARE = r_reg.cmp;
  assign BUF_PRIORITY = r_reg.pri;
  assign BUF_PROTECT = r_reg.pro;

  // Checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  sequence cmd_start(logic [3:0] c);
    WR && ADDR == OFF_CMD && r_reg.st == ST_IDLE && WDATA[3:0] == c
      && WDATA[23:20] == TGT_ADDR;
  endsequence

  sequence pin_steady;
    TEST_MODE_PIN[*5];
  endsequence

  test_gate_a: assert property (pin_steady |-> AU_NORMAL_GATE_DISABLE && PC_NORMAL_GATE_DISABLE)
    else $error("normal gates not disabled in test mode");
  hold_one_a: assert property (CRFILE_TEST_GATE_ENABLE && PC_TEST_GATE_ENABLE)
    else $error("test gate enable dropped");
  clear_all_a: assert property (@(posedge CLK) disable iff (1'b0) RST |=>
      r_reg.st == ST_IDLE && !COUNTER_LOCK_CTRL && XFER_EN == '0)
    else $error("master clear left controls set");
  src_switch_a: assert property (cmd_start(CMD_WR_SW) |-> ##2 BUS_SOURCE_SELECT
      && SECOND_AU_BUS == $past(r_reg.sw) && XFER_EN[EN_ADDR_IN])
    else $error("switch not placed on second bus");
  disp_copy_a: assert property (cmd_start(CMD_SW_DISP) |-> ##2 DISPLAY_LOAD_SELECT
      && DISPLAY_REGISTER == $past(r_reg.sw))
    else $error("switch not copied to display");
  reg_reset_a: assert property (cmd_start(CMD_REG_RESET) |-> ##2 XFER_EN[EN_VP_RES]
      ##1 !XFER_EN[EN_VP_RES])
    else $error("register reset control wrong");
  pc_lock_a: assert property (cmd_start(CMD_LOCK) |-> ##2 COUNTER_LOCK_CTRL)
    else $error("program counters not locked");
  slot_stop_a: assert property (SLOT_COUNTER_STOP |=> $stable(CUR_SLOT))
    else $error("slot counter moved while stopped");
  busy_seq_a: assert property (cmd_start(CMD_RD_MEM) |=> r_reg.st == ST_EXEC
      ##1 r_reg.st == ST_WAIT && XFER_EN[EN_RD_REQ])
    else $error("memory read did not go busy");
  mem_load_a: assert property (r_reg.st == ST_WAIT && r_reg.cmd[3:0] == CMD_RD_MEM
      && MEM_READY |=> r_reg.st == ST_IDLE && DISPLAY_REGISTER == $past(MAINT_DATA_BUS))
    else $error("memory data not loaded to display");
  ir_invert_a: assert property (MERGE_IR_READ_N != XFER_EN[EN_IR_OUT])
    else $error("instruction read enable not inverted");

endmodule
`default_nettype wire

//--- dv/mcf_far_model.sv
`timescale 1ns/1ps
`default_nettype none
// Far side: answers memory steps and drives the maintenance bus
module mcf_far_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [23:0] en,
  input  wire logic [3:0]  dly,
  input  wire logic [31:0] val,
  output logic             ready,
  output logic      [31:0] bus
);
  logic       pend;
  logic       held;
  logic       req_d;
  logic [3:0] cnt;
  // Data while a source is enabled, in the cycle after, or while ready is high; otherwise the inverse
  assign bus = (|(en & 24'h0334f0) | held | ready) ? val : ~val;
  // Memory or ROM step finishes after dly waiting cycles; a held write request counts once
  always @(posedge clk) begin
    held  <= |(en & 24'h0334f0);
    req_d <= en[19] | en[20] | en[8];
    ready <= 1'b0;
    if (rst) begin
      pend <= 1'b0;
    end else if ((en[19] | en[20] | en[8]) && !req_d) begin
      pend <= 1'b1;
      cnt  <= 4'h0;
    end else if (pend && cnt == dly) begin
      pend  <= 1'b0;
      ready <= 1'b1;
    end else if (pend) begin
      cnt <= cnt + 4'h1;
    end
  end
endmodule
`default_nettype wire

//--- dv/maintenance_control_fanout_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module maintenance_control_fanout_tb_top;
  import mcf_pkg::*;
  logic        clk = 0, rst = 1, wr = 0, rd = 0, rc = 0, rd_d = 0, tpin = 0;
  logic [7:0]  addr = 0;
  logic [3:0]  dly = 0;
  logic [31:0] wdata = 0, bval = 0, sw, v, r;
  logic [31:0] q[$];
  logic [31:0] cw[9] = '{32'h004003c5, 32'h00500035, 32'h00420002, 32'h00700205,
                         32'h5, 32'h00200006, 32'ha, 32'hb, 32'hc};
  int          eb[9] = '{9, 11, 10, 15, 0, 2, 21, 22, 23};
  logic [18:0] ev[9] = '{19'h64000, 19'hd, 19'h800, 19'h100, 0, 0, 0, 0, 0};
  int          num_errors = 0, checks = 0;
  wire  [8:0]  g;
  wire  [4:0]  lv;
  wire  [18:0] pv;
  wire  [23:0] xen;
  wire  [31:0] dr, rdata, maint_data_bus, au;
  wire  [7:0]  bv8;
  wire  [2:0]  ws;
  wire  [15:0] sl;
  wire         lk, cmpo, mrdy, ss;
  initial forever #2.5 clk = ~clk;
  mcf_top i_dut (
    .CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
    .TEST_MODE_PIN(tpin), .MAINT_DATA_BUS(maint_data_bus), .MEM_READY(mrdy), .TEST_MODE_INDICATOR(g[8]),
    .AU_NORMAL_GATE_DISABLE(g[0]), .CRFILE_NORMAL_GATE_DISABLE(g[1]),
    .PC_NORMAL_GATE_DISABLE(g[2]), .SYNC_BUFFER_TEST_ENABLE(g[3]),
    .CRFILE_TEST_GATE_ENABLE(g[4]), .PC_TEST_GATE_ENABLE(g[5]), .MERGE_IR_READ_N(g[6]),
    .MERGE_IR_LOAD_N(g[7]), .SECOND_AU_BUS(au), .BUS_SOURCE_SELECT(ss), .DISPLAY_LOAD_SELECT(),
    .DISPLAY_REGISTER(dr), .XFER_EN(xen), .COUNTER_LOCK_CTRL(lk), .HALT_ON_EVEN_STATE(lv[0]),
    .HALT_ON_ODD_STATE(lv[1]), .ASYNC_BUFFER_CTRL_ENABLE(lv[2]), .SLOT_COUNTER_STOP(lv[3]),
    .BUFFER_CTRL_TEST_LOCK(lv[4]), .BURST_VALUE(bv8), .REGFILE_BYTE_WE(pv[18:15]),
    .REGFILE_HALF_WE(pv[14:13]), .REGFILE_READ_SEL(pv[12:9]), .MICROINSTR_LOAD_SEL(pv[8:6]),
    .CRFILE_BYTE_WE(pv[5:2]), .CRFILE_HALF_WE(pv[1:0]), .WORD_SEL(ws), .LA3_VP_CODE(sl[8:6]),
    .LA3_ACTIVE(sl[9]), .LA2_BUF_AVAIL(sl[10]), .LA2_UNDER_TEST(sl[11]), .CUR_SLOT(sl[15:12]),
    .CUR_VP_CODE(sl[2:0]), .CUR_VP_ACTIVE(sl[3]), .COMPARE(cmpo), .BUF_PRIORITY(sl[4]),
    .BUF_PROTECT(sl[5]));
  mcf_far_model i_far (.clk(clk), .rst(rst), .en(xen), .dly(dly), .val(bval), .ready(mrdy),
    .bus(maint_data_bus));
  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] s);
    checks++;
    if (s !== e) begin
      num_errors++;
      $display("mismatch %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // One bus cycle; read data is taken mid-cycle after the strobe
  task automatic acc(input logic [7:0] a, input logic [31:0] d, input logic w, input logic c);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    rc <= c;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    @(negedge clk);
    v = rdata;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    q.push_back(e);
    acc(a, 0, 0, 1);
  endtask
  // Poll status until the busy bit clears
  task automatic idle();
    for (int i = 0; i < 40; i++) begin
      acc(OFF_STATUS, 0, 0, 0);
      if (v[0] === 1'b0) return;
    end
    num_errors++;
    print_verdict();
  endtask
  task automatic catch_en(input int b);
    for (int i = 0; i < 40; i++) begin
      @(negedge clk);
      if (xen[b] === 1'b1) return;
    end
    num_errors++;
    print_verdict();
  endtask
  // Read results are compared in the cycle after the strobe
  always @(posedge clk) rd_d <= rd & rc;
  always @(negedge clk) begin
    if (rd_d) begin
      cmp("rdata", q.pop_front(), rdata);
    end
  end
  initial begin
    void'($urandom(51461));
    sw = $urandom;
    bval = $urandom;
    repeat (20) @(posedge clk);
    cmp("gates", 9'h0f0, g);
    rst <= 1'b0;
    rd_chk(OFF_STATUS, 32'h10);
    rd_chk(8'h1c, 0);
    tpin <= 1'b1;
    repeat (6) @(posedge clk);
    cmp("gates", 9'h1ff, g);
    acc(OFF_SWITCH, sw, 1, 0);
    rd_chk(OFF_SWITCH, sw);
    acc(OFF_CMD, 32'h1, 1, 0);
    idle();
    rd_chk(OFF_DISPLAY, sw);
    cmp("compare", 1, cmpo);
    rd_chk(OFF_STATUS, 32'h18);
    // Memory read, then ROM read, prompt and slow far side
    for (int s = 0; s < 2; s++) begin
      dly <= 4'(s * 5);
      acc(OFF_CMD, 32'h3 + s, 1, 0);
      idle();
      cmp("display", bval, dr);
      cmp("au bus", sw, au);
      cmp("src sel", 1, ss);
      bval = $urandom;
    end
    // Pulsed enables and their decoded selects
    for (int i = 0; i < 9; i++) begin
      acc(OFF_CMD, cw[i] | (i == 8 ? sw & 32'hff000000 : 0), 1, 0);
      catch_en(eb[i]);
      cmp("pulses", ev[i], pv);
      cmp("word sel", cw[i][10:8], ws);
      idle();
    end
    cmp("burst", sw[31:24], bv8);
    for (int i = 0; i < 2; i++) begin
      acc(OFF_CMD, 32'h8 + i, 1, 0);
      idle();
      cmp("lock", !i, lk);
    end
    acc(OFF_CMD, 32'h0, 1, 0);
    idle();
    rd_chk(OFF_STATUS, 32'h0c);
    // Memory write: display register goes out on the second bus with the write request
    acc(OFF_CMD, 32'h7, 1, 0);
    catch_en(EN_WR_REQ);
    cmp("au bus", bval, au);
    cmp("src sel", 0, ss);
    idle();
    cmp("display", bval, dr);
    acc(OFF_CMD, 32'h1, 1, 0);
    idle();
    rd_chk(OFF_STATUS, 32'h18);
    // Slot 5: code 3, active, buffer free, under test; priority and protect set for code 3
    acc(OFF_PRIO, 32'h0808, 1, 0);
    acc(OFF_SLOT, 32'h053b, 1, 0);
    repeat (4) @(negedge clk);
    for (int i = 0; i < 40; i++) begin
      @(negedge clk);
      if (sl[15:12] == 4'h2) cmp("look three", 32'hb, sl[9:6]);
      if (sl[15:12] == 4'h3) cmp("look two", 32'h3, sl[11:10]);
      if (sl[15:12] == 4'h5) cmp("current", 32'h3b, sl[5:0]);
    end
    r = $urandom;
    acc(OFF_CTRL, r, 1, 0);
    rd_chk(OFF_CTRL, r[4:0]);
    cmp("levels", r[4:0], lv);
    repeat (2) @(posedge clk);
    print_verdict();
  end
endmodule
`default_nettype wire
